// file: rtl/ep_desc_pkg.sv
// constants for the endpoint descriptor store, decoder and serializer
// assumes a single clk_sys domain at 20 MHz with synchronous reset
package ep_desc_pkg;
	localparam logic [7:0] DESC_LEN      = 8'h07;
	localparam logic [7:0] DESC_TYPE_EP  = 8'h05;
	localparam logic [7:0] DESC_TYPE_CFG = 8'h02;
	localparam int         NUM_BYTES     = 7;
	// byte offsets inside the descriptor
	localparam logic [2:0] OFS_LEN       = 3'h0;
	localparam logic [2:0] OFS_TYPE      = 3'h1;
	localparam logic [2:0] OFS_ADDR      = 3'h2;
	localparam logic [2:0] OFS_ATTR      = 3'h3;
	localparam logic [2:0] OFS_MPS_LO    = 3'h4;
	localparam logic [2:0] OFS_MPS_HI    = 3'h5;
	localparam logic [2:0] OFS_IVAL      = 3'h6;
	// field positions
	localparam int ADDR_DIR_BIT  = 7;
	localparam int XFER_LSB      = 0;
	localparam int SYNC_LSB      = 2;
	localparam int USAGE_LSB     = 4;
	localparam int MULT_LSB      = 11;
	// register map of the plain port (byte-wide word per offset)
	localparam logic [3:0] REG_ADDR    = 4'h0;
	localparam logic [3:0] REG_ATTR    = 4'h1;
	localparam logic [3:0] REG_MPS_LO  = 4'h2;
	localparam logic [3:0] REG_MPS_HI  = 4'h3;
	localparam logic [3:0] REG_IVAL    = 4'h4;
	localparam logic [3:0] REG_CTRL    = 4'h5;
	localparam logic [3:0] REG_STATUS  = 4'h6;
	localparam logic [3:0] REG_DECODE  = 4'h7;
	// reset values: a legal full-speed bulk IN endpoint 1, 64 bytes
	localparam logic [7:0] RST_ADDR    = 8'h81;
	localparam logic [7:0] RST_ATTR    = 8'h02;
	localparam logic [7:0] RST_MPS_LO  = 8'h40;
	localparam logic [7:0] RST_MPS_HI  = 8'h00;
	localparam logic [7:0] RST_IVAL    = 8'h00;
	localparam logic [7:0] RST_CTRL    = 8'h00;
	// limits
	localparam logic [7:0]  IVAL_EXP_MAX = 8'h10;
	localparam logic [10:0] MPS_MULT2_MIN = 11'h201;
	localparam logic [10:0] MPS_MULT3_MIN = 11'h2AB;
	localparam logic [10:0] MPS_HS_MAX    = 11'h400;
	// timing units of the interval field
	localparam int FRAME_US      = 1000;
	localparam int UFRAME_NS     = 125000;
	typedef enum logic [1:0] {XFER_CTRL, XFER_ISO, XFER_BULK, XFER_INT} xfer_e;
	typedef enum logic [1:0] {SPEED_LOW, SPEED_FULL, SPEED_HIGH} speed_e;
endpackage

// file: rtl/ep_desc_if.sv
// carries the raw descriptor fields from store to checker and the verdict back
// assumes both ends sit in the clk_sys domain
interface ep_desc_if;
	import ep_desc_pkg::*;
	logic [7:0]  addr;
	logic [7:0]  attr;
	logic [15:0] mps;
	logic [7:0]  ival;
	logic [1:0]  speed;
	logic        bad_ep0;
	logic        bad_rsvd;
	logic        bad_ival;
	logic        bad_mps;
	logic        bad_fb;
	modport store (output addr, attr, mps, ival, speed,
		input bad_ep0, bad_rsvd, bad_ival, bad_mps, bad_fb);
	modport check (input addr, attr, mps, ival, speed,
		output bad_ep0, bad_rsvd, bad_ival, bad_mps, bad_fb);
endinterface

// file: rtl/ep_desc_check.sv
// combinational legality check of one endpoint descriptor
// assumes field values are stable registers of the parent
module ep_desc_check
	import ep_desc_pkg::*;
(
	ep_desc_if.check d
);
	xfer_e      xfer;
	logic [1:0] usage;
	logic [1:0] mult;
	logic [10:0] size;
	logic       hs;

	always_comb
	begin
		xfer  = xfer_e'(d.attr[XFER_LSB +: 2]);
		usage = d.attr[USAGE_LSB +: 2];
		mult  = d.mps[MULT_LSB +: 2];
		size  = d.mps[10:0];
		hs    = (d.speed == SPEED_HIGH);
		d.bad_ep0 = (d.addr[3:0] == 4'h0);
		d.bad_rsvd = (d.addr[6:4] != 3'h0)
			|| (d.attr[7:6] != 2'h0)
			|| ((xfer != XFER_ISO) && (d.attr[5:2] != 4'h0))
			|| ((xfer == XFER_ISO) && (usage == 2'h3))
			|| (d.mps[15:13] != 3'h0)
			|| (mult == 2'h3)
			|| ((mult != 2'h0) && !(hs && (xfer == XFER_ISO || xfer == XFER_INT)));
		d.bad_fb = (usage == 2'h1)
			&& ((xfer != XFER_ISO) || (d.attr[SYNC_LSB +: 2] != 2'h0));
		d.bad_mps = ((mult == 2'h1) && ((size < MPS_MULT2_MIN) || (size > MPS_HS_MAX)))
			|| ((mult == 2'h2) && ((size < MPS_MULT3_MIN) || (size > MPS_HS_MAX)));
		case (xfer)
			XFER_ISO:
				d.bad_ival = (d.speed != SPEED_LOW)
					&& ((d.ival == 8'h00) || (d.ival > IVAL_EXP_MAX));
			XFER_INT:
				if (hs)
					d.bad_ival = (d.ival == 8'h00) || (d.ival > IVAL_EXP_MAX);
				else
					d.bad_ival = (d.ival == 8'h00);
			default:
				d.bad_ival = 1'b0;
		endcase
	end
endmodule

// file: rtl/ep_desc_core.sv
// endpoint descriptor store, serializer and decoder
// assumes the request decoder upstream pulses get_cfg/get_ep and pops bytes
// Functional notes
// - descriptor bytes go out only during a configuration read
// - a direct endpoint get or set request is refused; the code stalls it only while the serializer is idle
// - endpoint zero is never reported
// - bytes: length, type, address, attributes, size low, size high, interval
// - address: number bits 3..0, bits 6..4 zero, bit 7 direction
// - attribute bits 1..0 give the transfer type
// - non-isochronous attribute bits 5..2 are reported zero
// - isochronous bits 3..2 give synchronization type
// - other attribute bits reported zero, ignored by host
// - size bits 10..0 give max payload bytes
// - high-speed periodic size bits 12..11 give extra transactions
// - size bits 15..13 reported zero
// - interval unit is 1 ms frame or 125 us microframe
// - isochronous interval 1..16, period two to value minus one; interval not checked at low speed
// - full/low-speed interrupt interval 1..255 frames directly
// - high-speed interrupt interval 1..16, exponential period
// - high-speed bulk/control OUT interval 0..255 as NAK rate
// - feedback usage requires isochronous with no synchronization
// - extra transaction codes force minimum packet sizes 513 or 683
//
// The implementer's own choices: the placing of the registers and strobed register access.
module ep_desc_core
	import ep_desc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic [1:0] speed,
	input  wire logic       get_cfg,
	input  wire logic       get_ep,
	input  wire logic       set_ep,
	input  wire logic       byte_pop,
	output logic      [7:0] byte_data,
	output logic            byte_valid,
	output logic            byte_last,
	output logic            req_stall,
	output logic      [3:0] ep_num,
	output logic            ep_dir_in,
	output logic      [1:0] ep_xfer,
	output logic      [1:0] ep_sync,
	output logic      [1:0] ep_usage,
	output logic     [10:0] ep_max_size,
	output logic      [1:0] ep_trans,
	output logic     [16:0] ep_period,
	output logic            malformed
);
	ep_desc_if d ();

	////////////////////////////////////////////////////////////////
	// software registers
	logic [7:0] addr_r, addr_nxt;
	logic [7:0] attr_r, attr_nxt;
	logic [7:0] mps_lo_r, mps_lo_nxt;
	logic [7:0] mps_hi_r, mps_hi_nxt;
	logic [7:0] ival_r, ival_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic       bad_any;

	assign d.addr  = addr_r;
	assign d.attr  = attr_r;
	assign d.mps   = {mps_hi_r, mps_lo_r};
	assign d.ival  = ival_r;
	assign d.speed = speed;
	assign bad_any = d.bad_ep0 | d.bad_rsvd | d.bad_ival | d.bad_mps | d.bad_fb;

	ep_desc_check u_check (
		.d (d.check)
	);

	always_comb
	begin
		addr_nxt   = addr_r;
		attr_nxt   = attr_r;
		mps_lo_nxt = mps_lo_r;
		mps_hi_nxt = mps_hi_r;
		ival_nxt   = ival_r;
		ctrl_nxt   = ctrl_r;
		if (reg_wr)
		begin
			case (reg_addr)
				REG_ADDR:   addr_nxt   = reg_wdata;
				REG_ATTR:   attr_nxt   = reg_wdata;
				REG_MPS_LO: mps_lo_nxt = reg_wdata;
				REG_MPS_HI: mps_hi_nxt = reg_wdata;
				REG_IVAL:   ival_nxt   = reg_wdata;
				REG_CTRL:   ctrl_nxt   = {7'h00, reg_wdata[0]};
				default:    ;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			addr_r   <= RST_ADDR;
			attr_r   <= RST_ATTR;
			mps_lo_r <= RST_MPS_LO;
			mps_hi_r <= RST_MPS_HI;
			ival_r   <= RST_IVAL;
			ctrl_r   <= RST_CTRL;
		end
		else
		begin
			addr_r   <= addr_nxt;
			attr_r   <= attr_nxt;
			mps_lo_r <= mps_lo_nxt;
			mps_hi_r <= mps_hi_nxt;
			ival_r   <= ival_nxt;
			ctrl_r   <= ctrl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// read port, one cycle latency
	logic [7:0] rdata_nxt;

	always_comb
	begin
		rdata_nxt = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				REG_ADDR:   rdata_nxt = addr_r;
				REG_ATTR:   rdata_nxt = attr_r;
				REG_MPS_LO: rdata_nxt = mps_lo_r;
				REG_MPS_HI: rdata_nxt = mps_hi_r;
				REG_IVAL:   rdata_nxt = ival_r;
				REG_CTRL:   rdata_nxt = ctrl_r;
				REG_STATUS: rdata_nxt = {2'h0, bad_any, d.bad_fb, d.bad_mps,
					d.bad_ival, d.bad_rsvd, d.bad_ep0};
				REG_DECODE: rdata_nxt = {ep_dir_in, 1'b0, ep_trans, ep_xfer, ep_usage};
				default:    rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= rdata_nxt;
	end

	////////////////////////////////////////////////////////////////
	// serializer: the descriptor leaves only inside a configuration read
	typedef enum logic [1:0] {SER_IDLE, SER_SEND, SER_STALL} ser_e;
	ser_e       ser_r, ser_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic [7:0] cur_byte;
	logic       enabled;

	// a malformed endpoint is withheld rather than sent to confuse the host
	assign enabled = ctrl_r[0] && !bad_any;

	always_comb
	begin
		case (idx_nxt)
			OFS_LEN:    cur_byte = DESC_LEN;
			OFS_TYPE:   cur_byte = DESC_TYPE_EP;
			OFS_ADDR:   cur_byte = addr_r;
			OFS_ATTR:   cur_byte = attr_r;
			OFS_MPS_LO: cur_byte = mps_lo_r;
			OFS_MPS_HI: cur_byte = mps_hi_r;
			OFS_IVAL:   cur_byte = ival_r;
			default:    cur_byte = 8'h00;
		endcase
	end

	always_comb
	begin
		ser_nxt = ser_r;
		idx_nxt = idx_r;
		case (ser_r)
			SER_IDLE:
				if (get_ep || set_ep)
					ser_nxt = SER_STALL;
				else if (get_cfg && enabled)
				begin
					ser_nxt = SER_SEND;
					idx_nxt = 3'h0;
				end
			SER_SEND:
				if (byte_pop)
				begin
					if (idx_r == 3'(NUM_BYTES - 1))
						ser_nxt = SER_IDLE;
					else
						idx_nxt = idx_r + 3'h1;
				end
			SER_STALL:
				ser_nxt = SER_IDLE;
			default:
				ser_nxt = SER_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			ser_r      <= SER_IDLE;
			idx_r      <= 3'h0;
			byte_data  <= 8'h00;
			byte_valid <= 1'b0;
			byte_last  <= 1'b0;
			req_stall  <= 1'b0;
		end
		else
		begin
			ser_r      <= ser_nxt;
			idx_r      <= idx_nxt;
			byte_valid <= (ser_nxt == SER_SEND);
			byte_data  <= (ser_nxt == SER_SEND) ? cur_byte : 8'h00;
			byte_last  <= (ser_nxt == SER_SEND) && (idx_nxt == 3'(NUM_BYTES - 1));
			req_stall  <= (ser_nxt == SER_STALL);
		end
	end

	////////////////////////////////////////////////////////////////
	// decoded view of the stored descriptor
	logic [16:0] period_nxt;
	logic [3:0]  ival_exp;

	always_comb
	begin
		ival_exp = (ival_r == 8'h00) ? 4'h0 : 4'(ival_r - 8'h01);
		case (xfer_e'(attr_r[XFER_LSB +: 2]))
			XFER_ISO:
				period_nxt = 17'h00001 << ival_exp;
			XFER_INT:
				if (speed == SPEED_HIGH)
					period_nxt = 17'h00001 << ival_exp;
				else
					period_nxt = {9'h000, ival_r};
			default:
				period_nxt = {9'h000, ival_r};
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			ep_num      <= 4'h0;
			ep_dir_in   <= 1'b0;
			ep_xfer     <= 2'h0;
			ep_sync     <= 2'h0;
			ep_usage    <= 2'h0;
			ep_max_size <= 11'h000;
			ep_trans    <= 2'h0;
			ep_period   <= 17'h00000;
			malformed   <= 1'b0;
		end
		else
		begin
			ep_num      <= addr_r[3:0];
			// direction is meaningless for control endpoints
			ep_dir_in   <= addr_r[ADDR_DIR_BIT]
				&& (attr_r[XFER_LSB +: 2] != 2'h0);
			ep_xfer     <= attr_r[XFER_LSB +: 2];
			ep_sync     <= (attr_r[1:0] == 2'h1) ? attr_r[SYNC_LSB +: 2] : 2'h0;
			ep_usage    <= (attr_r[1:0] == 2'h1) ? attr_r[USAGE_LSB +: 2] : 2'h0;
			ep_max_size <= mps_lo_r[7:0] == 8'h00 && mps_hi_r[2:0] == 3'h0
				? 11'h000 : {mps_hi_r[2:0], mps_lo_r};
			ep_trans    <= mps_hi_r[4:3];
			ep_period   <= period_nxt;
			malformed   <= bad_any;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	a_stall_on_direct: assert property (@(posedge clk_sys) disable iff (srst)
		(ser_r == SER_IDLE && (get_ep || set_ep)) |=> req_stall && !byte_valid)
		else $error("direct endpoint request not refused");
	a_send_needs_cfg: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(byte_valid) |-> $past(get_cfg) && byte_data == DESC_LEN)
		else $error("descriptor sent outside configuration read");
	a_no_ep0_sent: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(byte_valid) |-> addr_r[3:0] != 4'h0)
		else $error("endpoint zero reported");
	a_second_type: assert property (@(posedge clk_sys) disable iff (srst)
		(byte_valid && byte_pop && idx_r == OFS_LEN) |=> byte_data == DESC_TYPE_EP)
		else $error("descriptor type byte misplaced");
	a_last_is_ival: assert property (@(posedge clk_sys) disable iff (srst)
		byte_last |-> byte_valid && byte_data == ival_r)
		else $error("last byte not interval");
	a_ctrl_dir_zero: assert property (@(posedge clk_sys) disable iff (srst)
		##1 ($past(attr_r[1:0]) == 2'h0) |-> !ep_dir_in)
		else $error("control endpoint given a direction");
	a_malformed_rsvd: assert property (@(posedge clk_sys) disable iff (srst)
		(mps_hi_r[7:5] != 3'h0) |=> malformed)
		else $error("reserved size bits not flagged");
	a_period_exp: assert property (@(posedge clk_sys) disable iff (srst)
		(attr_r[1:0] == 2'h1 && ival_r == 8'h04) [*2] |-> ep_period == 17'h00008)
		else $error("isochronous period wrong");
	a_bad_mult_size: assert property (@(posedge clk_sys) disable iff (srst)
		(mps_hi_r[4:3] == 2'h1 && {mps_hi_r[2:0], mps_lo_r} < 11'h201) |-> d.bad_mps)
		else $error("short packet with extra transactions passed");
	a_fb_sync: assert property (@(posedge clk_sys) disable iff (srst)
		(attr_r[5:4] == 2'h1 && attr_r[3:2] != 2'h0) |-> bad_any ##1 malformed)
		else $error("feedback endpoint with sync passed");
endmodule

// file: verification/ep_host_model.sv
// host-side consumer of the descriptor byte stream, with a settable stall
// assumes the clk_sys domain and a level byte_pop taken with byte_valid
module ep_host_model
	import ep_desc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic [3:0] stall_cyc,
	input  wire logic [7:0] byte_data,
	input  wire logic       byte_valid,
	input  wire logic       byte_last,
	output logic            byte_pop = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rx [0:31];
	int         n_rx = 0;
	int         last_idx = -1;
	logic [3:0] wait_cnt = 4'h0;
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			byte_pop <= 1'b0;
			wait_cnt <= 4'h0;
			n_rx <= 0;
			last_idx <= -1;
		end
		else if (byte_pop && byte_valid)
		begin
			// drop pop after each byte so every byte sees the full stall
			rx[n_rx[4:0]] <= byte_data;
			if (byte_last)
				last_idx <= n_rx;
			n_rx <= n_rx + 1;
			byte_pop <= 1'b0;
		end
		else if (byte_valid)
		begin
			byte_pop <= (wait_cnt == stall_cyc);
			wait_cnt <= (wait_cnt == stall_cyc) ? 4'h0 : wait_cnt + 4'h1;
		end
	end
endmodule

// file: verification/endpoint_descriptor_decoder_tb_top.sv
// self-checking bench for the endpoint descriptor store and decoder
// assumes ep_desc_core, the host model and one 20 MHz clock
module endpoint_descriptor_decoder_tb_top
	import ep_desc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [16:0] SKIP = 17'h1FFFF;
	typedef struct packed {logic [7:0] a; logic [7:0] at; logic [15:0] m; logic [7:0] iv;
		logic [1:0] sp; logic bad; logic [16:0] per;} tc_s;
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [1:0]  speed = 2'h1;
	logic        get_cfg = 1'b0;
	logic        get_ep = 1'b0;
	logic        set_ep = 1'b0;
	logic [3:0]  stall_cyc = 4'h0;
	logic [7:0]  reg_rdata, byte_data;
	logic        byte_pop, byte_valid, byte_last, req_stall, ep_dir_in, malformed;
	logic [3:0]  ep_num;
	logic [1:0]  ep_xfer, ep_sync, ep_usage, ep_trans;
	logic [10:0] ep_max_size;
	logic [16:0] ep_period;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	tc_s         tcs [22] = '{
		{8'h81, 8'h05, 16'h03FF, 8'h04, 2'h1, 1'b0, 17'h00008},
		{8'h01, 8'h09, 16'h0040, 8'h01, 2'h1, 1'b0, 17'h00001},
		{8'h81, 8'h0D, 16'h0040, 8'h10, 2'h2, 1'b0, 17'h08000},
		{8'h81, 8'h11, 16'h0040, 8'h01, 2'h1, 1'b0, 17'h00001},
		{8'h81, 8'h15, 16'h0040, 8'h01, 2'h1, 1'b1, SKIP},
		{8'h81, 8'h21, 16'h0040, 8'h01, 2'h1, 1'b0, 17'h00001},
		{8'h81, 8'h31, 16'h0040, 8'h01, 2'h1, 1'b1, SKIP},
		{8'h81, 8'h06, 16'h0040, 8'h00, 2'h1, 1'b1, SKIP},
		{8'h81, 8'h42, 16'h0040, 8'h00, 2'h1, 1'b1, SKIP},
		{8'h81, 8'h03, 16'h0008, 8'hFF, 2'h1, 1'b0, 17'h000FF},
		{8'h81, 8'h03, 16'h0008, 8'h00, 2'h0, 1'b1, SKIP},
		{8'h81, 8'h03, 16'h0A00, 8'h10, 2'h2, 1'b1, SKIP},
		{8'h81, 8'h03, 16'h0A01, 8'h10, 2'h2, 1'b0, 17'h08000},
		{8'h81, 8'h03, 16'h12AA, 8'h01, 2'h2, 1'b1, SKIP},
		{8'h81, 8'h03, 16'h12AB, 8'h01, 2'h2, 1'b0, 17'h00001},
		{8'h81, 8'h03, 16'h0040, 8'h11, 2'h2, 1'b1, SKIP},
		{8'h81, 8'h01, 16'h2040, 8'h01, 2'h1, 1'b1, SKIP},
		{8'h91, 8'h02, 16'h0040, 8'h00, 2'h1, 1'b1, SKIP},
		{8'h01, 8'h02, 16'h0200, 8'hFF, 2'h2, 1'b0, 17'h000FF},
		{8'h85, 8'h00, 16'h0040, 8'h00, 2'h1, 1'b0, 17'h00000},
		{8'h81, 8'h01, 16'h0040, 8'h00, 2'h2, 1'b1, SKIP},
		{8'h81, 8'h03, 16'h1840, 8'h01, 2'h2, 1'b1, SKIP}};
	////////////////////////////////////////////////////////////////////////////////
	always #25 clk_sys = ~clk_sys;
	ep_desc_core dut_u (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.speed, .get_cfg, .get_ep, .set_ep, .byte_pop, .byte_data, .byte_valid, .byte_last,
		.req_stall, .ep_num, .ep_dir_in, .ep_xfer, .ep_sync, .ep_usage, .ep_max_size,
		.ep_trans, .ep_period, .malformed);
	ep_host_model mdl_u (.clk_sys, .srst, .stall_cyc, .byte_data, .byte_valid, .byte_last,
		.byte_pop);
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// k: 0 configuration read, 1 direct get, 2 direct set
	task automatic t_req(input int k, input int exp_st, input int exp_v);
		int ns = 0;
		int nv = 0;
		@(posedge clk_sys);
		get_cfg <= (k == 0);
		get_ep <= (k == 1);
		set_ep <= (k == 2);
		@(posedge clk_sys);
		{get_cfg, get_ep, set_ep} <= 3'h0;
		repeat (4)
		begin
			#1;
			ns += int'(req_stall === 1'b1);
			nv += int'(byte_valid === 1'b1);
			@(posedge clk_sys);
		end
		chk(17'(ns), 17'(exp_st), "stall pulses");
		chk(17'(nv), 17'(exp_v), "valid cycles");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [7:0] exp [8] = '{RST_ADDR, RST_ATTR, RST_MPS_LO, RST_MPS_HI, RST_IVAL, RST_CTRL,
			8'h00, 8'h88};
		logic [7:0] d;
		wr(4'hA, 8'h5A);
		for (int i = 0; i < 9; i++)
		begin
			rd(i < 8 ? 4'(i) : 4'hA, d);
			chk(d, i < 8 ? exp[i] : 8'h00, "register read");
		end
		chk({ep_dir_in, ep_num, ep_xfer}, 7'h46, "reset decode");
	endtask
	task automatic t_stream(input logic [3:0] st);
		logic [7:0] exp [7] = '{8'h07, 8'h05, RST_ADDR, RST_ATTR, 8'h40, 8'h00, 8'h00};
		int base;
		base = mdl_u.n_rx;
		stall_cyc <= st;
		t_req(0, 0, 4);
		for (int w = 0; w < 200 && mdl_u.n_rx < base + 7; w++)
			@(posedge clk_sys);
		for (int i = 0; i < 7; i++)
			chk(mdl_u.rx[base + i], exp[i], "stream byte");
		chk(17'(mdl_u.last_idx), 17'(base + 6), "last flag");
		repeat (2) @(posedge clk_sys);
		#1 chk(byte_valid, 1'b0, "valid after last");
	endtask
	task automatic t_ep0();
		logic [7:0] st;
		wr(REG_ADDR, 8'h00);
		repeat (3) @(posedge clk_sys);
		rd(REG_STATUS, st);
		chk({st[5], st[0], malformed}, 3'h7, "endpoint zero flagged");
		t_req(0, 0, 0);
	endtask
	task automatic t_table();
		logic [7:0] st;
		foreach (tcs[i])
		begin
			wr(REG_ADDR, tcs[i].a);
			wr(REG_ATTR, tcs[i].at);
			wr(REG_MPS_LO, tcs[i].m[7:0]);
			wr(REG_MPS_HI, tcs[i].m[15:8]);
			wr(REG_IVAL, tcs[i].iv);
			speed <= tcs[i].sp;
			repeat (3) @(posedge clk_sys);
			rd(REG_STATUS, st);
			chk({st[5], malformed}, {2{tcs[i].bad}}, "malformed");
			if (tcs[i].bad)
				t_req(0, 0, 0);
			else
			begin
				chk({ep_dir_in, ep_num}, {tcs[i].a[7] && (tcs[i].at[1:0] != 2'h0),
					tcs[i].a[3:0]}, "address");
				chk({ep_usage, ep_sync, ep_xfer}, tcs[i].at[5:0], "attr");
				chk(ep_max_size, tcs[i].m[10:0], "size");
				chk(ep_trans, tcs[i].m[12:11], "transactions");
				if (tcs[i].per != SKIP)
					chk(ep_period, tcs[i].per, "period");
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#(20000 * 50);
		n_mismatch++;
		tally_and_finish();
	end
	initial
	begin
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		t_regs();
		t_req(0, 0, 0);
		t_req(1, 1, 0);
		t_req(2, 1, 0);
		wr(REG_CTRL, 8'h01);
		t_stream(4'h0);
		t_stream(4'h3);
		t_req(2, 1, 0);
		t_ep0();
		t_table();
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		t_regs();
		tally_and_finish();
	end
endmodule
